// *** rtl/ulb_pkg.sv ***
// constants shared by the serial transceiver and its bench
package ulb_pkg;
   localparam int          DIV_W         = 8;
   localparam logic [7:0]  DIV_MIN       = 8'h04;
   localparam logic [7:0]  DIV_RESET     = 8'hff;
   localparam logic [7:0]  SHIFT_INIT    = 8'hff;
   localparam logic [4:0]  BRK_TX_BASE   = 5'h0d;
   localparam logic [4:0]  BRK_RX_MIN    = 5'h0b;
   localparam logic [3:0]  RX_STOP_LEN   = 4'h1;
   localparam int          FIFO_DEPTH    = 16;
   localparam logic [1:0]  PAR_NONE      = 2'h0;
   localparam logic [1:0]  PAR_ZERO      = 2'h1;
   localparam logic [1:0]  PAR_ODD       = 2'h2;
   localparam logic [1:0]  PAR_EVEN      = 2'h3;
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_BREAK} ulb_tx_st_t;
   typedef enum logic [2:0] {RX_WAIT, RX_CHECK, RX_DATA, RX_PAR, RX_STOP} ulb_rx_st_t;
endpackage : ulb_pkg

// *** rtl/ulb_fifo.sv ***
// synchronous valid/ready fifo for transmit characters
module ulb_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst_b,
   input  wire logic             i_flush,
   // fill side
   input  wire logic             i_valid,
   output logic                  o_ready,
   input  wire logic [WIDTH-1:0] i_data,
   // drain side
   output logic                  o_valid,
   input  wire logic             i_ready,
   output logic      [WIDTH-1:0] o_data
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_q;
   logic [AW:0]      rd_q;
   wire              full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   wire              empty = (wr_q == rd_q);
   wire              push  = i_valid && !full;
   wire              pop   = i_ready && !empty;
   assign o_ready = !full;
   assign o_valid = !empty;
   assign o_data  = mem[rd_q[AW-1:0]];
   always_ff @(posedge i_clk) begin
      if (push) mem[wr_q[AW-1:0]] <= i_data;
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_b || i_flush) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) wr_q <= wr_q + 1'b1;
         if (pop) rd_q <= rd_q + 1'b1;
      end
   end
endmodule : ulb_fifo

// *** rtl/ulb_uart.sv ***
// full-duplex serial unit with break transmit and break receive
module ulb_uart #(
   parameter int DATA_W  = 8,
   parameter int FIFO_D  = ulb_pkg::FIFO_DEPTH
) (
   // clock and reset
   input  wire logic              I_CORE_CLK,
   input  wire logic              I_RST_B,
   // control
   input  wire logic              I_UNIT_POWER_ENABLE,
   input  wire logic              I_TRANSMIT_ENABLE,
   input  wire logic              I_RECEIVE_ENABLE,
   input  wire logic              I_BASE_CLK_EN,
   input  wire logic [7:0]        I_BAUD_DIVISOR,
   input  wire logic [1:0]        I_PARITY_MODE,
   input  wire logic              I_TWO_STOP,
   input  wire logic [2:0]        I_BREAK_LENGTH_SELECT,
   input  wire logic              I_BREAK_TRANSMIT_SET,
   input  wire logic              I_BREAK_RECEIVE_SET,
   // transmit data register write
   input  wire logic              I_TX_WRITE,
   input  wire logic [DATA_W-1:0] I_TX_DATA,
   output logic                   O_TX_READY,
   // receive data register read and error flag clears (write 0)
   input  wire logic              I_RX_READ,
   input  wire logic              I_PE_CLR,
   input  wire logic              I_FE_CLR,
   input  wire logic              I_OVE_CLR,
   // status
   output logic                   O_BREAK_TRANSMIT_TRIGGER,
   output logic                   O_BREAK_RECEIVE_FLAG,
   output logic                   O_TRANSMIT_STATUS_FLAG,
   output logic                   O_RECEIVE_STATUS_FLAG,
   output logic                   O_PARITY_ERROR_FLAG,
   output logic                   O_FRAMING_ERROR_FLAG,
   output logic                   O_OVERRUN_ERROR_FLAG,
   output logic [DATA_W-1:0]      O_RX_DATA,
   // event pulses
   output logic                   O_TRANSMIT_BUFFER_FREE_IRQ,
   output logic                   O_RECEIVE_COMPLETE_IRQ,
   output logic                   O_RECEIVE_ERROR_IRQ,
   // serial pins
   input  wire logic              I_SERIAL_INPUT_PIN,
   output logic                   O_SERIAL_OUTPUT_PIN
);
   initial begin
      if (DATA_W != 8) $error("only 8-bit characters are supported");
   end

   wire tx_on = I_UNIT_POWER_ENABLE && I_TRANSMIT_ENABLE;
   wire rx_on = I_UNIT_POWER_ENABLE && I_RECEIVE_ENABLE;
   // a divisor below the minimum is clamped rather than left to misbehave
   wire [7:0] div = (I_BAUD_DIVISOR < ulb_pkg::DIV_MIN) ? ulb_pkg::DIV_MIN : I_BAUD_DIVISOR;

   function automatic logic par_bit(input logic [7:0] d, input logic [1:0] m);
      par_bit = (m == ulb_pkg::PAR_EVEN) ? ^d : (m == ulb_pkg::PAR_ODD) ? ~^d : 1'b0;
   endfunction : par_bit

   // ---------------- input synchroniser and noise filter
   logic sy1_q;
   logic sy2_q;
   logic ph_q;
   logic smp_q;
   logic filt_q;
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_B) begin
         sy1_q  <= 1'b1;
         sy2_q  <= 1'b1;
         ph_q   <= 1'b0;
         smp_q  <= 1'b1;
         filt_q <= 1'b1;
      end else begin
         sy1_q <= I_SERIAL_INPUT_PIN;
         sy2_q <= sy1_q;
         ph_q  <= ~ph_q;
         if (ph_q) begin
            smp_q <= sy2_q;
            if (smp_q == sy2_q) filt_q <= sy2_q;
         end
      end
   end

   // ---------------- transmit fifo
   logic              f_valid;
   logic              f_ready;
   logic [DATA_W-1:0] f_data;
   logic              f_pop;
   ulb_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_D)) u_fifo (
      .i_clk   (I_CORE_CLK),
      .i_rst_b (I_RST_B),
      .i_flush (!tx_on),
      .i_valid (I_TX_WRITE),
      .o_ready (f_ready),
      .i_data  (I_TX_DATA),
      .o_valid (f_valid),
      .i_ready (f_pop),
      .o_data  (f_data)
   );

   // ---------------- transmitter
   ulb_pkg::ulb_tx_st_t tx_st_q;
   logic [7:0]          tx_cnt_q;
   logic                tx_half_q;
   logic [4:0]          tx_bit_q;
   logic [7:0]          tx_sh_q;
   logic                tx_par_q;
   logic                stt_q;
   logic                txd_q;
   logic                tbf_q;
   logic                txr_q;
   wire  tx_tick = I_BASE_CLK_EN && (tx_cnt_q == div - 8'h01) && tx_half_q;
   wire  [4:0] brk_len = ulb_pkg::BRK_TX_BASE + {2'b00, I_BREAK_LENGTH_SELECT};
   wire  tx_free  = (tx_st_q == ulb_pkg::TX_IDLE) || (tx_tick && tx_st_q == ulb_pkg::TX_STOP
                    && tx_bit_q == {4'h0, I_TWO_STOP});
   wire  go_break = tx_free && stt_q && tx_st_q == ulb_pkg::TX_IDLE;
   assign f_pop   = tx_on && tx_free && f_valid && !go_break && !(stt_q && tx_st_q == ulb_pkg::TX_IDLE);

   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_B || !tx_on) begin
         tx_st_q   <= ulb_pkg::TX_IDLE;
         tx_cnt_q  <= '0;
         tx_half_q <= 1'b0;
         tx_bit_q  <= '0;
         tx_sh_q   <= ulb_pkg::SHIFT_INIT;
         tx_par_q  <= 1'b0;
         stt_q     <= 1'b0;
         txd_q     <= 1'b1;
         tbf_q     <= 1'b0;
      end else begin
         tbf_q <= 1'b0;
         if (I_BREAK_TRANSMIT_SET) stt_q <= 1'b1;
         if (I_BASE_CLK_EN) begin
            if (tx_cnt_q == div - 8'h01) begin
               tx_cnt_q  <= '0;
               tx_half_q <= ~tx_half_q;
            end else begin
               tx_cnt_q <= tx_cnt_q + 8'h01;
            end
         end
         if (go_break) begin
            tx_st_q   <= ulb_pkg::TX_BREAK;
            tx_bit_q  <= '0;
            tx_cnt_q  <= '0;
            tx_half_q <= 1'b0;
            txd_q     <= 1'b0;
            tbf_q     <= 1'b1;
         end else if (f_pop) begin
            tx_st_q   <= ulb_pkg::TX_START;
            tx_sh_q   <= f_data;
            tx_par_q  <= par_bit(f_data, I_PARITY_MODE);
            tx_bit_q  <= '0;
            tx_cnt_q  <= '0;
            tx_half_q <= 1'b0;
            txd_q     <= 1'b0;
            tbf_q     <= 1'b1;
         end else if (tx_tick) begin
            case (tx_st_q)
               ulb_pkg::TX_START: begin
                  tx_st_q <= ulb_pkg::TX_DATA;
                  txd_q   <= tx_sh_q[0];
               end
               ulb_pkg::TX_DATA: begin
                  tx_sh_q  <= {1'b1, tx_sh_q[7:1]};
                  tx_bit_q <= tx_bit_q + 5'h01;
                  if (tx_bit_q == 5'h07) begin
                     tx_bit_q <= '0;
                     tx_st_q  <= (I_PARITY_MODE == ulb_pkg::PAR_NONE) ? ulb_pkg::TX_STOP : ulb_pkg::TX_PAR;
                     txd_q    <= (I_PARITY_MODE == ulb_pkg::PAR_NONE) ? 1'b1 : tx_par_q;
                  end else begin
                     txd_q <= tx_sh_q[1];
                  end
               end
               ulb_pkg::TX_PAR: begin
                  tx_st_q <= ulb_pkg::TX_STOP;
                  txd_q   <= 1'b1;
               end
               ulb_pkg::TX_STOP: begin
                  tx_bit_q <= tx_bit_q + 5'h01;
                  if (tx_bit_q == {4'h0, I_TWO_STOP}) tx_st_q <= ulb_pkg::TX_IDLE;
               end
               ulb_pkg::TX_BREAK: begin
                  tx_bit_q <= tx_bit_q + 5'h01;
                  if (tx_bit_q == brk_len - 5'h01) begin
                     txd_q   <= 1'b1;
                     stt_q   <= 1'b0;
                     tx_st_q <= ulb_pkg::TX_IDLE;
                  end
               end
               default: tx_st_q <= ulb_pkg::TX_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_B) txr_q <= 1'b0;
      else txr_q <= f_ready && tx_on;
   end

   // ---------------- receiver
   ulb_pkg::ulb_rx_st_t rx_st_q;
   logic [7:0]          rx_cnt_q;
   logic                rx_half_q;
   logic [4:0]          rx_bit_q;
   logic [7:0]          rx_sh_q;
   logic                rx_par_q;
   logic                rx_allzero_q;
   logic                filt_d1_q;
   logic                srf_q;
   logic                rsf_q;
   logic                pe_q;
   logic                fe_q;
   logic                ove_q;
   logic                full_q;
   logic [7:0]          rxd_q;
   logic                rc_q;
   logic                re_q;
   // sample point is the bit centre; one bit time is two divisor periods
   wire  rx_tick  = I_BASE_CLK_EN && (rx_cnt_q == div - 8'h01) && rx_half_q;
   wire  rx_fall  = filt_d1_q && !filt_q;
   wire  par_exp  = (I_PARITY_MODE == ulb_pkg::PAR_ODD) ? ~^rx_sh_q : ^rx_sh_q;
   wire  par_bad  = (I_PARITY_MODE == ulb_pkg::PAR_EVEN || I_PARITY_MODE == ulb_pkg::PAR_ODD)
                    && (filt_q != par_exp);
   // break length in bits counted low before the stop level
   wire  [4:0] low_bits = rx_bit_q + 5'h01;
   wire  brk_ok   = rx_allzero_q && (low_bits >= ulb_pkg::BRK_RX_MIN);
   wire  set_pe   = rx_tick && rx_st_q == ulb_pkg::RX_PAR && par_bad && !srf_q;
   wire  stop_at  = rx_tick && rx_st_q == ulb_pkg::RX_STOP;
   wire  brk_end  = srf_q && rx_tick && rx_st_q != ulb_pkg::RX_CHECK && rx_st_q != ulb_pkg::RX_WAIT && filt_q;
   wire  norm_end = stop_at && !srf_q;
   wire  fe_now   = norm_end && !filt_q;
   wire  ov_now   = norm_end && full_q;

   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_B) begin
         filt_d1_q <= 1'b1;
      end else begin
         filt_d1_q <= filt_q;
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_B || !rx_on) begin
         rx_st_q      <= ulb_pkg::RX_WAIT;
         rx_cnt_q     <= '0;
         rx_half_q    <= 1'b0;
         rx_bit_q     <= '0;
         rx_sh_q      <= ulb_pkg::SHIFT_INIT;
         rx_allzero_q <= 1'b1;
         srf_q        <= 1'b0;
         rsf_q        <= 1'b0;
         rc_q         <= 1'b0;
         re_q         <= 1'b0;
      end else begin
         rc_q <= 1'b0;
         re_q <= 1'b0;
         if (I_BREAK_RECEIVE_SET) srf_q <= 1'b1;
         if (I_BASE_CLK_EN) begin
            if (rx_cnt_q == div - 8'h01) begin
               rx_cnt_q  <= '0;
               rx_half_q <= ~rx_half_q;
            end else begin
               rx_cnt_q <= rx_cnt_q + 8'h01;
            end
         end
         case (rx_st_q)
            ulb_pkg::RX_WAIT: begin
               if (rx_fall) begin
                  rx_st_q   <= ulb_pkg::RX_CHECK;
                  rx_cnt_q  <= '0;
                  rx_half_q <= 1'b0;
               end
            end
            ulb_pkg::RX_CHECK: begin
               if (I_BASE_CLK_EN && rx_cnt_q == div - 8'h01) begin
                  rx_cnt_q  <= '0;
                  rx_half_q <= 1'b0;
                  rx_bit_q  <= '0;
                  rx_allzero_q <= 1'b1;
                  rx_st_q   <= filt_q ? ulb_pkg::RX_WAIT : ulb_pkg::RX_DATA;
                  rsf_q     <= !filt_q;
               end
            end
            ulb_pkg::RX_DATA: begin
               if (brk_end) begin
                  rsf_q   <= 1'b0;
                  rx_st_q <= ulb_pkg::RX_WAIT;
               end else if (rx_tick) begin
                  if (filt_q) rx_allzero_q <= 1'b0;
                  if (!srf_q) rx_sh_q <= {filt_q, rx_sh_q[7:1]};
                  rx_bit_q <= rx_bit_q + 5'h01;
                  if (rx_bit_q == 5'h07 && !srf_q)
                     rx_st_q <= (I_PARITY_MODE == ulb_pkg::PAR_NONE) ? ulb_pkg::RX_STOP : ulb_pkg::RX_PAR;
               end
            end
            ulb_pkg::RX_PAR: begin
               if (rx_tick) rx_st_q <= ulb_pkg::RX_STOP;
            end
            ulb_pkg::RX_STOP: begin
               if (rx_tick) begin
                  rsf_q   <= 1'b0;
                  rx_st_q <= ulb_pkg::RX_WAIT;
                  rc_q    <= !fe_now && !ov_now && !pe_q && !set_pe;
                  re_q    <= fe_now || ov_now || pe_q;
               end
            end
            default: rx_st_q <= ulb_pkg::RX_WAIT;
         endcase
         if (brk_end) begin
            if (brk_ok) begin
               rc_q  <= 1'b1;
               srf_q <= 1'b0;
            end // short break: silent return to break-wait, flag kept
            rx_sh_q <= ulb_pkg::SHIFT_INIT;
         end
         if (rx_st_q == ulb_pkg::RX_DATA && rx_tick && srf_q && !filt_q && rx_bit_q == 5'h1f)
            rx_st_q <= ulb_pkg::RX_WAIT;
      end
   end

   // errors, receive data and buffer occupancy; set wins over a software clear
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_B || !I_UNIT_POWER_ENABLE) begin
         pe_q   <= 1'b0;
         fe_q   <= 1'b0;
         ove_q  <= 1'b0;
         full_q <= 1'b0;
         rxd_q  <= ulb_pkg::SHIFT_INIT;
      end else begin
         pe_q  <= set_pe || (pe_q && !I_PE_CLR);
         fe_q  <= fe_now || (fe_q && !I_FE_CLR);
         ove_q <= ov_now || (ove_q && !I_OVE_CLR);
         if (norm_end && !full_q) begin
            rxd_q  <= rx_sh_q;
            full_q <= 1'b1;
         end else if (I_RX_READ) begin
            full_q <= 1'b0;
         end
      end
   end

   // busy while a frame or break shifts or characters wait; flag must be 0 before reinit
   logic txs_q;
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_B) txs_q <= 1'b0;
      else txs_q <= tx_on && (tx_st_q != ulb_pkg::TX_IDLE || f_valid);
   end

   // ---------------- outputs
   assign O_TX_READY                 = txr_q;
   assign O_BREAK_TRANSMIT_TRIGGER   = stt_q;
   assign O_BREAK_RECEIVE_FLAG       = srf_q;
   assign O_TRANSMIT_STATUS_FLAG     = txs_q;
   assign O_RECEIVE_STATUS_FLAG      = rsf_q;
   assign O_PARITY_ERROR_FLAG        = pe_q;
   assign O_FRAMING_ERROR_FLAG       = fe_q;
   assign O_OVERRUN_ERROR_FLAG       = ove_q;
   assign O_RX_DATA                  = rxd_q;
   assign O_TRANSMIT_BUFFER_FREE_IRQ = tbf_q;
   assign O_RECEIVE_COMPLETE_IRQ     = rc_q;
   assign O_RECEIVE_ERROR_IRQ        = re_q;
   assign O_SERIAL_OUTPUT_PIN        = txd_q;
endmodule : ulb_uart

// *** bench/ulb_uart_sva.sv ***
// port-level checks for the serial transceiver
module ulb_uart_sva #(
   parameter int DATA_W = 8
) (
   // clock, reset and framing error clear
   input wire logic              I_CORE_CLK,
   input wire logic              I_RST_B,
   input wire logic              I_FE_CLR,
   // status and data
   input wire logic [DATA_W-1:0] O_RX_DATA,
   input wire logic              O_BREAK_TRANSMIT_TRIGGER,
   input wire logic              O_BREAK_RECEIVE_FLAG,
   input wire logic              O_TRANSMIT_STATUS_FLAG,
   input wire logic              O_RECEIVE_STATUS_FLAG,
   input wire logic              O_PARITY_ERROR_FLAG,
   input wire logic              O_FRAMING_ERROR_FLAG,
   input wire logic              O_OVERRUN_ERROR_FLAG,
   // pulses and pin
   input wire logic              O_TRANSMIT_BUFFER_FREE_IRQ,
   input wire logic              O_RECEIVE_COMPLETE_IRQ,
   input wire logic              O_RECEIVE_ERROR_IRQ,
   input wire logic              O_SERIAL_OUTPUT_PIN
);
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RST_B);

   a_free_then_start: assert property (O_TRANSMIT_BUFFER_FREE_IRQ |-> ##[0:2] !O_SERIAL_OUTPUT_PIN)
      else $error("buffer free without start level");
   a_brk_end_high: assert property ($fell(O_BREAK_TRANSMIT_TRIGGER) |-> ##[0:2] O_SERIAL_OUTPUT_PIN)
      else $error("break trigger cleared while pin low");
   a_tx_idle_high: assert property ((!O_TRANSMIT_STATUS_FLAG && !O_BREAK_TRANSMIT_TRIGGER) [*2] |-> O_SERIAL_OUTPUT_PIN)
      else $error("idle transmitter not high");
   a_cmp_no_busy: assert property (O_RECEIVE_COMPLETE_IRQ |-> !O_RECEIVE_STATUS_FLAG)
      else $error("receive complete while still busy");
   a_irq_exclusive: assert property (!(O_RECEIVE_COMPLETE_IRQ && O_RECEIVE_ERROR_IRQ))
      else $error("complete and error together");
   a_ovr_keeps_data: assert property ($rose(O_OVERRUN_ERROR_FLAG) |-> $stable(O_RX_DATA) ##1 $stable(O_RX_DATA))
      else $error("overrun overwrote data");
   // the error pulse follows at the stop sample, one bit time (up to 510 clocks) after parity
   a_pe_sets_err: assert property ($rose(O_PARITY_ERROR_FLAG) |-> ##[1:512] O_RECEIVE_ERROR_IRQ)
      else $error("parity flag without error pulse");
   // a clear two cycles clear of any stop sample must win
   a_fe_clear: assert property (I_FE_CLR && !O_RECEIVE_STATUS_FLAG && !$past(O_RECEIVE_STATUS_FLAG) |=> !O_FRAMING_ERROR_FLAG)
      else $error("framing flag not cleared");
   a_brk_rx_done: assert property ($fell(O_BREAK_RECEIVE_FLAG) |-> $past(O_RECEIVE_COMPLETE_IRQ) or O_RECEIVE_COMPLETE_IRQ or ##1 O_RECEIVE_COMPLETE_IRQ)
      else $error("break end without complete pulse");
   a_brk_hold_data: assert property (O_BREAK_RECEIVE_FLAG |=> $stable(O_RX_DATA) && !$rose(O_OVERRUN_ERROR_FLAG))
      else $error("break wait disturbed receive data");
endmodule : ulb_uart_sva

// *** bench/ulb_remote_node.sv ***
// behavioural remote node: frame sender, frame monitor, low-width meter
module ulb_remote_node #(
   parameter int BIT = 8
) (
   input  wire logic       i_clk,
   input  wire logic       i_line,
   input  wire logic [1:0] i_par_mode,
   output logic            o_line
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] frame_q[$];
   int         gap_q[$];
   int         low_run = 0;
   int         run = 0;

   // the bus rests high, driven to 1 before the first frame
   initial o_line = 1'b1;

   function automatic logic par_of(input logic [7:0] d, input logic [1:0] m);
      return (m == ulb_pkg::PAR_EVEN) ? ^d : (m == ulb_pkg::PAR_ODD) ? ~^d : 1'b0;
   endfunction : par_of

   task automatic bit_out(input logic v, input int n);
      o_line <= v;
      repeat (n) @(posedge i_clk);
   endtask : bit_out

   // bad flips the parity bit, stp is the stop level
   task automatic send(input logic [7:0] d, input logic bad, input logic stp);
      bit_out(1'b0, BIT);
      for (int b = 0; b < 8; b++) bit_out(d[b], BIT);
      if (i_par_mode != ulb_pkg::PAR_NONE) bit_out(par_of(d, i_par_mode) ^ bad, BIT);
      bit_out(stp, BIT);
      bit_out(1'b1, 2 * BIT);
   endtask : send

   // samples at bit centres; gap counts cycles from the last stop-bit centre sample to the next start
   always begin : mon
      int         g;
      logic [7:0] d;
      logic       p;
      g = 0;
      p = 1'b0;
      while (i_line !== 1'b1) @(posedge i_clk);
      while (i_line !== 1'b0) begin
         @(posedge i_clk);
         g++;
      end
      repeat (BIT / 2) @(posedge i_clk);
      for (int b = 0; b < 8; b++) begin
         repeat (BIT) @(posedge i_clk);
         d[b] = i_line;
      end
      if (i_par_mode != ulb_pkg::PAR_NONE) begin
         repeat (BIT) @(posedge i_clk);
         p = i_line;
      end
      repeat (BIT) @(posedge i_clk);
      frame_q.push_back({i_line, p, d});
      gap_q.push_back(g);
   end

   always @(posedge i_clk) begin
      if (i_line === 1'b0) run <= run + 1;
      else begin
         if (run != 0) low_run <= run;
         run <= 0;
      end
   end
endmodule : ulb_remote_node

// *** bench/tb_ulb_uart.sv ***
// self-checking bench for the serial transceiver
module tb_ulb_uart;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BIT = 2 * ulb_pkg::DIV_MIN;
   logic       clk, rst_b, pwr, txe, rxe, brk_tx, brk_rx, tx_wr, rx_rd, pe_clr, fe_clr, ove_clr, pin_in, pin_out;
   logic       tx_rdy, brk_trig, brk_flag, tsf, rsf, pe, fe, ove, irq_free, irq_cmp, irq_err;
   logic [7:0] tx_d, rx_d;
   logic [2:0] bsel;
   logic [1:0] par;
   int         bad_count = 0, cmp_count = 0, n_free = 0, n_cmp = 0, n_err = 0, acc, acc2;

   ulb_uart uut (.I_CORE_CLK(clk), .I_RST_B(rst_b), .I_UNIT_POWER_ENABLE(pwr), .I_TRANSMIT_ENABLE(txe),
      .I_RECEIVE_ENABLE(rxe), .I_BASE_CLK_EN(1'b1), .I_BAUD_DIVISOR(ulb_pkg::DIV_MIN), .I_PARITY_MODE(par),
      .I_TWO_STOP(1'b0), .I_BREAK_LENGTH_SELECT(bsel), .I_BREAK_TRANSMIT_SET(brk_tx), .I_BREAK_RECEIVE_SET(brk_rx),
      .I_TX_WRITE(tx_wr), .I_TX_DATA(tx_d), .O_TX_READY(tx_rdy), .I_RX_READ(rx_rd), .I_PE_CLR(pe_clr),
      .I_FE_CLR(fe_clr), .I_OVE_CLR(ove_clr), .O_BREAK_TRANSMIT_TRIGGER(brk_trig), .O_BREAK_RECEIVE_FLAG(brk_flag),
      .O_TRANSMIT_STATUS_FLAG(tsf), .O_RECEIVE_STATUS_FLAG(rsf), .O_PARITY_ERROR_FLAG(pe), .O_FRAMING_ERROR_FLAG(fe),
      .O_OVERRUN_ERROR_FLAG(ove), .O_RX_DATA(rx_d), .O_TRANSMIT_BUFFER_FREE_IRQ(irq_free),
      .O_RECEIVE_COMPLETE_IRQ(irq_cmp), .O_RECEIVE_ERROR_IRQ(irq_err), .I_SERIAL_INPUT_PIN(pin_in),
      .O_SERIAL_OUTPUT_PIN(pin_out));
   ulb_remote_node #(.BIT(BIT)) peer (.i_clk(clk), .i_line(pin_out), .i_par_mode(par), .o_line(pin_in));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(posedge clk) begin
      if (irq_free === 1'b1) n_free <= n_free + 1;
      if (irq_cmp === 1'b1) n_cmp <= n_cmp + 1;
      if (irq_err === 1'b1) n_err <= n_err + 1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] d);
      tx_wr <= 1'b1;
      tx_d  <= d;
      tick(1);
      tx_wr <= 1'b0;
      tick(1);
   endtask : wr

   task automatic wait_idle();
      tick(4);
      for (int w = 0; w < 4000 && tsf !== 1'b0; w++) tick(1);
      tick(2 * BIT);
   endtask : wait_idle

   function automatic logic [9:0] fx(input logic [7:0] d);
      return {1'b1, peer.par_of(d, par), d};
   endfunction : fx

   task automatic summarize();
      if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : summarize

   initial begin
      tick(30000);
      bad_count++;
      summarize();
   end

   initial begin
      {rst_b, pwr, txe, rxe, brk_tx, brk_rx, tx_wr, rx_rd, pe_clr, fe_clr, ove_clr} = '0;
      tx_d = '0;
      bsel = '0;
      par  = '0;
      tick(8);
      rst_b <= 1'b1;
      pwr   <= 1'b1;
      tick(1);
      chk(pin_out, 1'b1);
      chk(rx_d, ulb_pkg::SHIFT_INIT);
      txe <= 1'b1;
      rxe <= 1'b1;
      tick(2);
      // two characters per parity mode, the second queued during the first
      for (int m = 0; m < 4; m++) begin
         par <= m[1:0];
         tick(1);
         acc = n_free;
         peer.frame_q.delete();
         peer.gap_q.delete();
         wr(8'h96 ^ m[7:0]);
         wr(8'h80 >> m);
         wait_idle();
         chk(n_free - acc, 2);
         chk(peer.frame_q.size(), 2);
         chk(peer.frame_q[0], fx(8'h96 ^ m[7:0]));
         chk(peer.frame_q[1], fx(8'h80 >> m));
         chk(peer.gap_q[1] <= BIT / 2 + 3, 1'b1);
      end
      // fill the fifo until refused while the line drains it slowly
      peer.frame_q.delete();
      acc = 0;
      for (int i = 0; i < 20; i++) begin
         tick(1);
         if (tx_rdy === 1'b1) begin
            wr(i[7:0]);
            acc++;
         end
      end
      chk(tx_rdy, 1'b0);
      wait_idle();
      chk(peer.frame_q.size(), acc);
      for (int i = 0; i < acc; i++) chk(peer.frame_q[i], fx(i[7:0]));
      chk(tx_rdy, 1'b1);
      txe <= 1'b0;
      tick(2);
      txe <= 1'b1;
      tick(2);
      // receive in every parity mode, good and corrupted parity
      for (int m = 0; m < 8; m++) begin
         par <= m[2:1];
         tick(1);
         acc  = n_cmp;
         acc2 = n_err;
         peer.send(8'ha5 ^ m[7:0], m[0], 1'b1);
         tick(BIT);
         chk(rx_d, 8'ha5 ^ m[7:0]);
         chk(n_err - acc2, m[0] & m[2]);
         chk(n_cmp - acc, !(m[0] & m[2]));
         chk(pe, m[0] & m[2]);
         pe_clr <= 1'b1;
         rx_rd  <= 1'b1;
         tick(1);
         pe_clr <= 1'b0;
         rx_rd  <= 1'b0;
         tick(1);
         chk(pe, 1'b0);
      end
      // framing error, then overrun with the buffer left unread
      par <= ulb_pkg::PAR_NONE;
      tick(1);
      acc2 = n_err;
      fork
         peer.send(8'h3c, 1'b0, 1'b0);
         begin
            tick(5 * BIT);
            chk(rsf, 1'b1);
         end
      join
      chk(fe, 1'b1);
      chk(rx_d, 8'h3c);
      fe_clr <= 1'b1;
      tick(1);
      fe_clr <= 1'b0;
      tick(1);
      chk(fe, 1'b0);
      peer.send(8'hc3, 1'b0, 1'b1);
      chk(ove, 1'b1);
      chk(rx_d, 8'h3c);
      chk(n_err - acc2, 2);
      ove_clr <= 1'b1;
      tick(1);
      ove_clr <= 1'b0;
      tick(1);
      // break reception: too short, then long enough
      acc  = n_cmp;
      acc2 = n_err;
      brk_rx <= 1'b1;
      tick(1);
      brk_rx <= 1'b0;
      tick(1);
      chk(brk_flag, 1'b1);
      peer.bit_out(1'b0, 10 * BIT);
      peer.bit_out(1'b1, 4 * BIT);
      chk(brk_flag, 1'b1);
      chk(n_cmp - acc, 0);
      peer.bit_out(1'b0, 11 * BIT);
      peer.bit_out(1'b1, 4 * BIT);
      chk(brk_flag, 1'b0);
      chk(n_cmp - acc, 1);
      chk(n_err - acc2, 0);
      chk(rx_d, 8'h3c);
      chk(ove, 1'b0);
      // a glitch shorter than half a bit is no start
      peer.bit_out(1'b0, 3);
      peer.bit_out(1'b1, 4 * BIT);
      chk(n_cmp + n_err - acc - acc2, 1);
      chk(rsf, 1'b0);
      // break transmission at both ends of the width range
      for (int s = 0; s < 8; s += 7) begin
         bsel <= s[2:0];
         acc = n_free;
         brk_tx <= 1'b1;
         tick(1);
         brk_tx <= 1'b0;
         tick(2);
         chk(brk_trig, 1'b1);
         for (int w = 0; w < 4000 && brk_trig !== 1'b0; w++) tick(1);
         tick(4);
         chk(peer.low_run, (13 + s) * BIT);
         chk(n_free - acc, 1);
         chk(pin_out, 1'b1);
      end
      summarize();
   end
endmodule : tb_ulb_uart

bind ulb_uart ulb_uart_sva #(.DATA_W(DATA_W)) u_sva (.I_CORE_CLK(I_CORE_CLK), .I_RST_B(I_RST_B),
   .I_FE_CLR(I_FE_CLR), .O_RX_DATA(O_RX_DATA), .O_BREAK_TRANSMIT_TRIGGER(O_BREAK_TRANSMIT_TRIGGER),
   .O_BREAK_RECEIVE_FLAG(O_BREAK_RECEIVE_FLAG), .O_TRANSMIT_STATUS_FLAG(O_TRANSMIT_STATUS_FLAG),
   .O_RECEIVE_STATUS_FLAG(O_RECEIVE_STATUS_FLAG), .O_PARITY_ERROR_FLAG(O_PARITY_ERROR_FLAG),
   .O_FRAMING_ERROR_FLAG(O_FRAMING_ERROR_FLAG), .O_OVERRUN_ERROR_FLAG(O_OVERRUN_ERROR_FLAG),
   .O_TRANSMIT_BUFFER_FREE_IRQ(O_TRANSMIT_BUFFER_FREE_IRQ), .O_RECEIVE_COMPLETE_IRQ(O_RECEIVE_COMPLETE_IRQ),
   .O_RECEIVE_ERROR_IRQ(O_RECEIVE_ERROR_IRQ), .O_SERIAL_OUTPUT_PIN(O_SERIAL_OUTPUT_PIN));
